// File: verilog/ds3o_oof_top.sv
// Purpose: DS3 receive out-of-frame declaration during frame maintenance
// Assumes: Bit-position strobes come from framer logic on the line clock
// Notes: Only the out-of-frame change bit of the interrupt status is kept

module ds3o_oof_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fSyncFound,
  input wire logic fBitStb,
  input wire logic fBitErr,
  input wire logic mFrameStb,
  input wire logic mBitErr,
  input wire logic pBitErr,
  input wire logic [15:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic intN,
  output logic frameLoss,
  output logic inFrame
);

  import ds3o_pkg::*;

  logic rstSync1_q;
  logic rstSync2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  wire logic rstN = rstSync2_q;

  ds3o_state_t state_q;
  ds3o_state_t state_d;
  logic [2:0] cfg_q;
  logic [1:0] mMatch_q;
  logic [1:0] mMatch_d;
  logic frameLoss_q;
  logic oofChg_q;
  logic intN_q;
  logic inFrame_q;
  logic [7:0] regRdData_q;

  wire logic cfgMsync = cfg_q[CFG_MSYNC_BIT];
  wire logic cfgFsel = cfg_q[CFG_FSEL_BIT];
  wire logic cfgPq = cfg_q[CFG_PQ_BIT];
  wire logic inMaint = (state_q == ST_INFRAME);
  wire logic winClr = !inMaint;

  // Framing threshold follows the select bit
  wire logic [4:0] fThr = cfgFsel ? F_THR_TIGHT :
                          F_THR_LOOSE;

  logic [4:0] fCnt;
  logic fHit;
  logic [2:0] mCnt;
  logic mHit;
  logic [2:0] pCnt;
  logic pHit;

  ds3o_window #(.N(F_WIN), .CW(F_CW)) u_fwin (
    .clk(clk),
    .rstN(rstN),
    .clr(winClr),
    .sampleValid(fBitStb && inMaint),
    .sampleErr(fBitErr),
    .threshold(fThr),
    .errCount(fCnt),
    .hit(fHit)
  );

  ds3o_window #(.N(M_WIN), .CW(M_CW)) u_mwin (
    .clk(clk),
    .rstN(rstN),
    .clr(winClr),
    .sampleValid(mFrameStb && inMaint),
    .sampleErr(mBitErr),
    .threshold(M_THR),
    .errCount(mCnt),
    .hit(mHit)
  );

  ds3o_window #(.N(P_WIN), .CW(P_CW)) u_pwin (
    .clk(clk),
    .rstN(rstN),
    .clr(winClr),
    .sampleValid(mFrameStb && inMaint),
    .sampleErr(pBitErr),
    .threshold(P_THR),
    .errCount(pCnt),
    .hit(pHit)
  );

  // Multiframe and parity criteria are gated by their enables and ORed with framing
  wire logic mCrit = cfgMsync && mHit;
  wire logic pCrit = cfgPq && pHit;
  wire logic oofDeclare = inMaint && (fHit || mCrit || pCrit);
  wire logic mGood = mFrameStb && !mBitErr;
  wire logic enterFrame = (state_d == ST_INFRAME) && !inMaint;

  always_comb begin
    state_d = state_q;
    mMatch_d = mMatch_q;
    unique case (state_q)
      ST_SEARCH: begin
        mMatch_d = 2'h0;
        if (fSyncFound) begin
          state_d = ST_MSYNC;
        end
      end
      ST_MSYNC: begin
        if (mFrameStb && mBitErr) begin
          state_d = ST_SEARCH;
          mMatch_d = 2'h0;
        end else if (mGood && mMatch_q == M_MATCH_LAST) begin
          state_d = cfgPq ? ST_PCHECK : ST_INFRAME;
          mMatch_d = 2'h0;
        end else if (mGood) begin
          mMatch_d = mMatch_q + 2'h1;
        end
      end
      ST_PCHECK: begin
        if (mFrameStb) begin
          state_d = pBitErr ? ST_SEARCH : ST_INFRAME;
        end
      end
      ST_INFRAME: begin
        if (oofDeclare) begin
          state_d = ST_SEARCH;
        end
      end
    endcase
  end

  wire logic frameLoss_d = oofDeclare ? 1'b1 :
                           (enterFrame ? 1'b0 : frameLoss_q);
  wire logic chgEvt = oofDeclare || enterFrame;
  wire logic cfgWrite = regWrEn && (regAddr == ADDR_CFG_STAT);
  wire logic irqRead = regRdEn && (regAddr == ADDR_IRQ_STAT);
  // A change in the read cycle keeps the bit set
  wire logic oofChg_d = chgEvt || (oofChg_q && !irqRead);

  wire logic [7:0] cfgView = {3'h0, frameLoss_q, 1'b0, cfg_q};
  wire logic [7:0] irqView = {6'h00, oofChg_q, 1'b0};
  wire logic [7:0] rdMux = (regAddr == ADDR_CFG_STAT) ? cfgView :
                           ((regAddr == ADDR_IRQ_STAT) ? irqView : 8'h00);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_SEARCH;
      mMatch_q <= 2'h0;
      frameLoss_q <= LOSS_RESET;
      oofChg_q <= 1'b0;
      intN_q <= 1'b1;
      inFrame_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mMatch_q <= mMatch_d;
      frameLoss_q <= frameLoss_d;
      oofChg_q <= oofChg_d;
      intN_q <= !oofChg_d;
      inFrame_q <= (state_d == ST_INFRAME);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cfg_q <= CFG_RW_RESET;
      regRdData_q <= 8'h00;
    end else begin
      if (cfgWrite) begin
        cfg_q <= regWrData[2:0];
      end
      regRdData_q <= regRdEn ? rdMux : 8'h00;
    end
  end

  assign regRdData = regRdData_q;
  assign intN = intN_q;
  assign frameLoss = frameLoss_q;
  assign inFrame = inFrame_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  property p_f_loose;
    inMaint && !cfgFsel && (fCnt >= 5'h06) |=> state_q == ST_SEARCH;
  endproperty
  a_f_loose: assert property (p_f_loose)
    else $error("six framing errors did not end frame");

  property p_f_tight;
    inMaint && cfgFsel && (fCnt >= 5'h03) |=> state_q == ST_SEARCH;
  endproperty
  a_f_tight: assert property (p_f_tight)
    else $error("three framing errors did not end frame");

  property p_f_hold;
    inMaint && !cfgMsync && !cfgPq && (fCnt < fThr) |=> inMaint;
  endproperty
  a_f_hold: assert property (p_f_hold)
    else $error("frame lost below framing threshold");

  property p_m_crit;
    inMaint && cfgMsync && (mCnt >= 3'h3) |=> !inMaint && frameLoss_q;
  endproperty
  a_m_crit: assert property (p_m_crit)
    else $error("multiframe criterion did not declare");

  property p_p_crit;
    inMaint && cfgPq && (pCnt >= 3'h2) |=> state_q == ST_SEARCH;
  endproperty
  a_p_crit: assert property (p_p_crit)
    else $error("parity criterion did not declare");

  property p_pq_entry;
    !inMaint ##1 inMaint |-> $past(state_q) == ($past(cfgPq) ?
                               ST_PCHECK : ST_MSYNC);
  endproperty
  a_pq_entry: assert property (p_pq_entry)
    else $error("in frame entered by wrong path");

  property p_loss_set;
    oofDeclare |=> frameLoss_q && oofChg_q && !intN_q;
  endproperty
  a_loss_set: assert property (p_loss_set)
    else $error("declaration not flagged");

  property p_entry_flag;
    !inMaint ##1 inMaint |-> !frameLoss_q && oofChg_q;
  endproperty
  a_entry_flag: assert property (p_entry_flag)
    else $error("frame entry not flagged");

  property p_chg_irq;
    $changed(frameLoss_q) |-> oofChg_q ##0 !intN_q;
  endproperty
  a_chg_irq: assert property (p_chg_irq)
    else $error("change without interrupt");

  property p_rd_clear;
    irqRead && !chgEvt |=> !oofChg_q && intN_q;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("read did not clear interrupt");

  c_enter: cover property (state_q == ST_MSYNC ##[1:200] inMaint);
  c_pq_enter: cover property (state_q == ST_PCHECK ##[1:200] inMaint);
  c_oof: cover property (inMaint ##[1:200] oofDeclare);
  c_race: cover property (irqRead && chgEvt);

endmodule : ds3o_oof_top

// File: verilog/ds3o_pkg.sv
// Purpose: Shared constants and types for the DS3 out-of-frame block
// Assumes: 8-bit registers, byte addresses as printed
// Notes: Thresholds are typed at the width of the window counters
package ds3o_pkg;

  localparam logic [15:0] ADDR_CFG_STAT = 16'h1110;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h1113;

  localparam int CFG_MSYNC_BIT = 0;
  localparam int CFG_FSEL_BIT = 1;
  localparam int CFG_PQ_BIT = 2;
  localparam int CFG_LOSS_BIT = 4;
  localparam int IRQ_OOF_BIT = 1;

  localparam logic [2:0] CFG_RW_RESET = 3'h4;
  localparam logic LOSS_RESET = 1'b1;

  localparam int F_WIN = 16;
  localparam int F_CW = 5;
  localparam logic [4:0] F_THR_LOOSE = 5'h06;
  localparam logic [4:0] F_THR_TIGHT = 5'h03;
  localparam int M_WIN = 4;
  localparam int M_CW = 3;
  localparam logic [2:0] M_THR = 3'h3;
  localparam int P_WIN = 5;
  localparam int P_CW = 3;
  localparam logic [2:0] P_THR = 3'h2;
  localparam logic [1:0] M_MATCH_LAST = 2'h2;

  typedef enum logic [1:0] {
    ST_SEARCH = 2'b00,
    ST_MSYNC = 2'b01,
    ST_PCHECK = 2'b10,
    ST_INFRAME = 2'b11
  } ds3o_state_t;

endpackage : ds3o_pkg

// File: verilog/ds3o_window.sv
// Purpose: Sliding window of the last N error flags with a count and a hit
// Assumes: One sample per valid strobe, same clock as the consumer
// Notes: Clear empties the history so a new maintenance run starts fresh
module ds3o_window #(
  parameter int N = 16,
  parameter int CW = 5
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic clr,
  input wire logic sampleValid,
  input wire logic sampleErr,
  input wire logic [CW-1:0] threshold,
  output logic [CW-1:0] errCount,
  output logic hit
);

  if (N < 2 || CW != $clog2(N + 1)) begin : g_chk
    $error("ds3o_window: N must be at least 2 and CW must fit N");
  end

  function automatic logic [CW-1:0] popCount(input logic [N-1:0] v);
    logic [CW-1:0] c;
    c = '0;
    for (int i = 0; i < N; i++) begin
      c = c + {{(CW-1){1'b0}}, v[i]};
    end
    return c;
  endfunction : popCount

  logic [N-1:0] hist_q;
  wire logic [N-1:0] histShift = {hist_q[N-2:0], sampleErr};
  wire logic [N-1:0] hist_d = clr ? '0 :
                              (sampleValid ? histShift : hist_q);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      hist_q <= '0;
    end else begin
      hist_q <= hist_d;
    end
  end

  assign errCount = popCount(hist_q);
  assign hit = (errCount >= threshold);

  property p_win_clear;
    @(posedge clk) disable iff (!rstN)
    clr |=> (errCount == '0) && (!hit || (threshold == '0));
  endproperty
  a_win_clear: assert property (p_win_clear)
    else $error("window not empty after clear");

endmodule : ds3o_window

// File: testbench/ds3o_line_model.sv
// Purpose: Line-side strobe source standing in for the framer front end
// Assumes: Strobes change on the falling edge, one clock wide
// Notes: Qualifiers flip after each strobe so stale values never match
module ds3o_line_model (
  input wire logic clk,
  output logic fSyncFound,
  output logic fBitStb,
  output logic fBitErr,
  output logic mFrameStb,
  output logic mBitErr,
  output logic pBitErr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {fSyncFound, fBitStb, fBitErr, mFrameStb, mBitErr, pBitErr} = 6'h00;
  end

  task automatic sync();
    @(negedge clk);
    fSyncFound = 1'b1;
    @(negedge clk);
    fSyncFound = 1'b0;
  endtask : sync

  task automatic fBit(input logic e);
    @(negedge clk);
    fBitStb = 1'b1;
    fBitErr = e;
    @(negedge clk);
    fBitStb = 1'b0;
    fBitErr = ~e;
  endtask : fBit

  task automatic mFrame(input logic mE, input logic pE);
    @(negedge clk);
    mFrameStb = 1'b1;
    mBitErr = mE;
    pBitErr = pE;
    @(negedge clk);
    mFrameStb = 1'b0;
    mBitErr = ~mE;
    pBitErr = ~pE;
  endtask : mFrame
endmodule : ds3o_line_model

// File: testbench/ds3o_oof_top_tb.sv
// Purpose: Self-checking bench for the out-of-frame block
// Assumes: Register strobes and line strobes driven on falling edges
// Notes: Each out-of-frame scenario acquires frame first, then injects errors
module ds3o_oof_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ds3o_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fSyncFound, fBitStb, fBitErr, mFrameStb, mBitErr, pBitErr;
  logic [15:0] regAddr = 16'h0000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic intN, frameLoss, inFrame;
  int failCount = 0;
  int numChecks = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  ds3o_oof_top i_dut (.clk(clk), .rst_n(rst_n), .fSyncFound(fSyncFound),
    .fBitStb(fBitStb), .fBitErr(fBitErr), .mFrameStb(mFrameStb),
    .mBitErr(mBitErr), .pBitErr(pBitErr), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .intN(intN), .frameLoss(frameLoss),
    .inFrame(inFrame));

  ds3o_line_model i_line (.clk(clk), .fSyncFound(fSyncFound),
    .fBitStb(fBitStb), .fBitErr(fBitErr), .mFrameStb(mFrameStb),
    .mBitErr(mBitErr), .pBitErr(pBitErr));

  task automatic wrapUp();
    if (failCount == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrapUp

  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: read %h not %h", $time, got, exp);
    end
  endtask : chkReg

  task automatic chkPin(input logic got, input logic exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: pin %b not %b", $time, got, exp);
    end
  endtask : chkPin

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic regWr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : regWr

  task automatic expReg(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    chkReg(regRdData, exp);
  endtask : expReg

  task automatic acquire(input logic pq);
    i_line.sync();
    repeat (2) i_line.mFrame(1'b0, 1'b0);
    chkPin(inFrame, 1'b0);
    i_line.mFrame(1'b0, 1'b0);
    if (pq) begin
      chkPin(inFrame, 1'b0);
      i_line.mFrame(1'b0, 1'b0);
    end
    idle(2);
    chkPin(inFrame, 1'b1);
    chkPin(frameLoss, 1'b0);
    chkPin(intN, 1'b0);
    expReg(ADDR_IRQ_STAT, 8'h02);
    chkPin(intN, 1'b1);
  endtask : acquire

  task automatic expOof();
    idle(2);
    chkPin(inFrame, 1'b0);
    chkPin(frameLoss, 1'b1);
    chkPin(intN, 1'b0);
    expReg(ADDR_IRQ_STAT, 8'h02);
    expReg(ADDR_IRQ_STAT, 8'h00);
  endtask : expOof

  initial begin
    int thr;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    idle(3);
    chkPin(intN, 1'b1);
    expReg(ADDR_CFG_STAT, 8'h14);
    expReg(16'h1111, 8'h00);
    regWr(ADDR_CFG_STAT, 8'hf8);
    expReg(ADDR_CFG_STAT, 8'h10);
    for (int s = 0; s < 2; s++) begin
      thr = (s == 0) ? 6 : 3;
      regWr(ADDR_CFG_STAT, 8'(s * 2));
      acquire(1'b0);
      repeat (thr - 1) i_line.fBit(1'b1);
      repeat (16) i_line.fBit(1'b0);
      repeat (thr - 1) i_line.fBit(1'b1);
      idle(2);
      chkPin(inFrame, 1'b1);
      i_line.fBit(1'b1);
      expOof();
    end
    i_line.sync();
    i_line.mFrame(1'b1, 1'b0);
    repeat (3) i_line.mFrame(1'b0, 1'b0);
    chkPin(inFrame, 1'b0);
    regWr(ADDR_CFG_STAT, 8'h00);
    acquire(1'b0);
    repeat (4) i_line.mFrame(1'b1, 1'b1);
    idle(2);
    chkPin(inFrame, 1'b1);
    repeat (6) i_line.fBit(1'b1);
    expOof();
    regWr(ADDR_CFG_STAT, 8'h01);
    acquire(1'b0);
    i_line.mFrame(1'b1, 1'b0);
    i_line.mFrame(1'b0, 1'b0);
    i_line.mFrame(1'b1, 1'b0);
    idle(2);
    chkPin(inFrame, 1'b1);
    i_line.mFrame(1'b1, 1'b0);
    expOof();
    regWr(ADDR_CFG_STAT, 8'h04);
    i_line.sync();
    repeat (3) i_line.mFrame(1'b0, 1'b0);
    i_line.mFrame(1'b0, 1'b1);
    idle(2);
    chkPin(inFrame, 1'b0);
    acquire(1'b1);
    i_line.mFrame(1'b0, 1'b1);
    repeat (3) i_line.mFrame(1'b0, 1'b0);
    idle(2);
    chkPin(inFrame, 1'b1);
    i_line.mFrame(1'b0, 1'b1);
    expOof();
    wrapUp();
  end

  initial begin
    #300us;
    failCount++;
    wrapUp();
  end
endmodule : ds3o_oof_top_tb
